/* File: rtl/flash_host_pkg.sv */
// package of command codes, addresses, opcodes and timing counts for the flash host controller
package flash_host_pkg;

  // ==========================================================================
  // bus geometry
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // ==========================================================================
  // unlock and command addresses (low address bits only)
  localparam logic [11:0] UNLOCK_ADDR_A = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR_B = 12'h2AA;
  localparam logic [11:0] QUERY_ADDR    = 12'h055;
  localparam logic [11:0] ANY_ADDR      = 12'h000;

  // ==========================================================================
  // identification offsets inside a bank
  localparam logic [11:0] ID_MAKER_OFS  = 12'h000;
  localparam logic [11:0] ID_PART1_OFS  = 12'h001;
  localparam logic [11:0] ID_PROT_OFS   = 12'h002;
  localparam logic [11:0] ID_LOCK_OFS   = 12'h003;
  localparam logic [11:0] ID_PART2_OFS  = 12'h00E;
  localparam logic [11:0] ID_PART3_OFS  = 12'h00F;

  // ==========================================================================
  // command data codes (low byte only)
  localparam logic [7:0] CODE_UNLOCK_A  = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK_B  = 8'h55;
  localparam logic [7:0] CODE_RESET     = 8'hF0;
  localparam logic [7:0] CODE_IDENT     = 8'h90;
  localparam logic [7:0] CODE_OTP_ENTER = 8'h88;
  localparam logic [7:0] CODE_EXIT_ZERO = 8'h00;
  localparam logic [7:0] CODE_PROGRAM   = 8'hA0;
  localparam logic [7:0] CODE_BYPASS    = 8'h20;
  localparam logic [7:0] CODE_ERASE_SET = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERS  = 8'h10;
  localparam logic [7:0] CODE_SECT_ERS  = 8'h30;
  localparam logic [7:0] CODE_SUSPEND   = 8'hB0;
  localparam logic [7:0] CODE_RESUME    = 8'h30;
  localparam logic [7:0] CODE_QUERY     = 8'h98;

  // ==========================================================================
  // status bit positions in read data
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int LIMIT_BIT  = 5;
  localparam int WINDOW_BIT = 3;
  localparam int SECTOR_BIT = 2;

  // ==========================================================================
  // bank field position: top three address bits
  localparam int BANK_LSB = 19;
  localparam int BANK_W   = 3;
  localparam int SECT_LSB = 12;

  // ==========================================================================
  // bus timing in clock cycles at 25 MHz
  localparam int CLOCK_MHZ        = 25;
  localparam int STROBE_NS        = 80;
  localparam int STROBE_CYCLES    = (STROBE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SETUP_NS         = 40;
  localparam int SETUP_CYCLES     = (SETUP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int ERASE_WINDOW_US  = 80;
  localparam int ERASE_WINDOW_CYC = ERASE_WINDOW_US * CLOCK_MHZ;
  localparam int CNT_W            = 8;

  // ==========================================================================
  // user operations
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_IDENT, OP_OTP_ENTER, OP_OTP_EXIT, OP_PROGRAM,
    OP_BYPASS_ENTER, OP_BYPASS_PROGRAM, OP_BYPASS_EXIT, OP_CHIP_ERASE,
    OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_QUERY, OP_ID_READ, OP_POLL
  } op_t;

  // one bus cycle of a sequence
  typedef struct packed {
    logic              is_read;
    logic [11:0]       ofs;
    logic              use_bank;
    logic              use_full;
    logic [7:0]        code;
    logic              use_word;
    logic              last;
  } step_t;

endpackage : flash_host_pkg

/* File: rtl/flash_cycle_if.sv */
// interface carrying one bus cycle request and its answer between sequencer and pin driver
`timescale 1ns/100ps
interface flash_cycle_if;
  import flash_host_pkg::*;
  logic                is_read;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic                start;
  logic                done;
  logic [DATA_W-1:0]   rdata;

  modport seq (output is_read, output addr, output wdata, output start, input done, input rdata);
  modport drv (input is_read, input addr, input wdata, input start, output done, output rdata);
endinterface : flash_cycle_if

/* File: rtl/flash_bus_driver.sv */
// pin driver: performs one asynchronous read or write cycle on the flash pins
`timescale 1ns/100ps
module flash_bus_driver
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  // cycle request
  flash_cycle_if.drv             cyc,
  // flash pins
  output logic [ADDR_W-1:0]      pin_addr_out,
  output logic [DATA_W-1:0]      pin_data_out,
  output logic                   pin_data_oe_out,
  input  wire logic [DATA_W-1:0] pin_data_in,
  output logic                   chip_sel_n_out,
  output logic                   write_n_out,
  output logic                   read_n_out
);

  typedef enum logic [1:0] {D_IDLE, D_SETUP, D_STROBE, D_HOLD} dstate_t;

  typedef struct packed {
    dstate_t             st;
    logic [CNT_W-1:0]    cnt;
    logic                is_read;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic                oe;
    logic                cs_n;
    logic                we_n;
    logic                re_n;
    logic                done;
    logic [DATA_W-1:0]   rdata;
    logic [DATA_W-1:0]   sync1;
    logic [DATA_W-1:0]   sync2;
  } drv_state_t;

  drv_state_t s_reg;
  drv_state_t s_next;

  // chip select falls with the address, strobe falls later, so the later edge latches a stable address
  always_comb begin
    s_next       = s_reg;
    s_next.done  = 1'b0;
    s_next.sync1 = pin_data_in;
    s_next.sync2 = s_reg.sync1;
    unique case (s_reg.st)
      D_IDLE: begin
        if (cyc.start) begin
          s_next.is_read = cyc.is_read;
          s_next.addr    = cyc.addr;
          s_next.wdata   = cyc.wdata;
          s_next.oe      = !cyc.is_read;
          s_next.cs_n    = 1'b0;
          s_next.cnt     = CNT_W'(SETUP_CYCLES);
          s_next.st      = D_SETUP;
        end
      end
      D_SETUP: begin
        if (s_reg.cnt <= CNT_W'(1)) begin
          s_next.we_n = s_reg.is_read;
          s_next.re_n = !s_reg.is_read;
          s_next.cnt  = CNT_W'(STROBE_CYCLES + 2);
          s_next.st   = D_STROBE;
        end else begin
          s_next.cnt = s_reg.cnt - CNT_W'(1);
        end
      end
      D_STROBE: begin
        if (s_reg.cnt <= CNT_W'(1)) begin
          // write strobe rises first while data still stands, so data latches on it
          s_next.we_n  = 1'b1;
          s_next.re_n  = 1'b1;
          s_next.rdata = s_reg.sync2;
          s_next.st    = D_HOLD;
        end else begin
          s_next.cnt = s_reg.cnt - CNT_W'(1);
        end
      end
      D_HOLD: begin
        s_next.cs_n = 1'b1;
        s_next.oe   = 1'b0;
        s_next.done = 1'b1;
        s_next.st   = D_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s_reg      <= '0;
      s_reg.st   <= D_IDLE;
      s_reg.cs_n <= 1'b1;
      s_reg.we_n <= 1'b1;
      s_reg.re_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // pins straight from flops
  assign pin_addr_out    = s_reg.addr;
  assign pin_data_out    = s_reg.wdata;
  assign pin_data_oe_out = s_reg.oe;
  assign chip_sel_n_out  = s_reg.cs_n;
  assign write_n_out     = s_reg.we_n;
  assign read_n_out      = s_reg.re_n;
  assign cyc.done        = s_reg.done;
  assign cyc.rdata       = s_reg.rdata;

endmodule : flash_bus_driver

/* File: rtl/flash_seq_rom.sv */
// sequence table: maps an operation and step index to one bus cycle description
`timescale 1ns/100ps
module flash_seq_rom
  import flash_host_pkg::*;
(
  // lookup
  input  wire op_t          op_in,
  input  wire logic [2:0]   idx_in,
  input  wire logic [11:0]  id_ofs_in,
  output step_t             step_out
);

  // build one step
  function automatic step_t mk(input logic rd, input logic [11:0] ofs, input logic bank, input logic full,
                               input logic [7:0] code, input logic word, input logic last);
    mk = '{is_read: rd, ofs: ofs, use_bank: bank, use_full: full, code: code, use_word: word, last: last};
  endfunction

  // the two unlock writes open most sequences
  function automatic step_t unlock(input logic [2:0] i);
    unlock = (i[0] == 1'b0) ? mk(1'b0, UNLOCK_ADDR_A, 1'b0, 1'b0, CODE_UNLOCK_A, 1'b0, 1'b0)
                            : mk(1'b0, UNLOCK_ADDR_B, 1'b0, 1'b0, CODE_UNLOCK_B, 1'b0, 1'b0);
  endfunction

  always_comb begin
    step_out = mk(1'b1, 12'h000, 1'b0, 1'b1, 8'h00, 1'b0, 1'b1);
    unique case (op_in)
      OP_READ, OP_POLL: step_out = mk(1'b1, 12'h000, 1'b0, 1'b1, 8'h00, 1'b0, 1'b1);
      OP_RESET: step_out = mk(1'b0, ANY_ADDR, 1'b0, 1'b0, CODE_RESET, 1'b0, 1'b1);
      OP_IDENT, OP_ID_READ: begin
        if (op_in == OP_ID_READ)
          step_out = mk(1'b1, id_ofs_in, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1);
        else if (idx_in < 3'd2)
          step_out = unlock(idx_in);
        else
          step_out = mk(1'b0, UNLOCK_ADDR_A, 1'b1, 1'b0, CODE_IDENT, 1'b0, 1'b1);
      end
      OP_OTP_ENTER:
        step_out = (idx_in < 3'd2) ? unlock(idx_in) : mk(1'b0, UNLOCK_ADDR_A, 1'b0, 1'b0, CODE_OTP_ENTER, 1'b0, 1'b1);
      OP_OTP_EXIT: begin
        if (idx_in < 3'd2)      step_out = unlock(idx_in);
        else if (idx_in == 3'd2) step_out = mk(1'b0, UNLOCK_ADDR_A, 1'b0, 1'b0, CODE_IDENT, 1'b0, 1'b0);
        else                     step_out = mk(1'b0, ANY_ADDR, 1'b0, 1'b0, CODE_EXIT_ZERO, 1'b0, 1'b1);
      end
      OP_PROGRAM: begin
        if (idx_in < 3'd2)      step_out = unlock(idx_in);
        else if (idx_in == 3'd2) step_out = mk(1'b0, UNLOCK_ADDR_A, 1'b0, 1'b0, CODE_PROGRAM, 1'b0, 1'b0);
        else                     step_out = mk(1'b0, 12'h000, 1'b0, 1'b1, 8'h00, 1'b1, 1'b1);
      end
      OP_BYPASS_ENTER:
        step_out = (idx_in < 3'd2) ? unlock(idx_in) : mk(1'b0, UNLOCK_ADDR_A, 1'b0, 1'b0, CODE_BYPASS, 1'b0, 1'b1);
      OP_BYPASS_PROGRAM:
        step_out = (idx_in == 3'd0) ? mk(1'b0, ANY_ADDR, 1'b0, 1'b0, CODE_PROGRAM, 1'b0, 1'b0)
                                    : mk(1'b0, 12'h000, 1'b0, 1'b1, 8'h00, 1'b1, 1'b1);
      OP_BYPASS_EXIT:
        step_out = (idx_in == 3'd0) ? mk(1'b0, ANY_ADDR, 1'b0, 1'b0, CODE_IDENT, 1'b0, 1'b0)
                                    : mk(1'b0, ANY_ADDR, 1'b0, 1'b0, CODE_EXIT_ZERO, 1'b0, 1'b1);
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
        if (idx_in == 3'd2)
          step_out = mk(1'b0, UNLOCK_ADDR_A, 1'b0, 1'b0, CODE_ERASE_SET, 1'b0, 1'b0);
        else if (idx_in < 3'd5)
          step_out = unlock(idx_in == 3'd3 ? 3'd0 : (idx_in == 3'd4 ? 3'd1 : idx_in));
        else if (op_in == OP_CHIP_ERASE)
          step_out = mk(1'b0, UNLOCK_ADDR_A, 1'b0, 1'b0, CODE_CHIP_ERS, 1'b0, 1'b1);
        else
          step_out = mk(1'b0, 12'h000, 1'b0, 1'b1, CODE_SECT_ERS, 1'b0, 1'b1);
      end
      OP_SUSPEND: step_out = mk(1'b0, ANY_ADDR, 1'b1, 1'b0, CODE_SUSPEND, 1'b0, 1'b1);
      OP_RESUME:  step_out = mk(1'b0, ANY_ADDR, 1'b1, 1'b0, CODE_RESUME, 1'b0, 1'b1);
      OP_QUERY:   step_out = mk(1'b0, QUERY_ADDR, 1'b0, 1'b0, CODE_QUERY, 1'b0, 1'b1);
    endcase
  end

endmodule : flash_seq_rom

/* File: rtl/flash_command_decoder.sv */
// host controller that issues flash command sequences and decodes status from the device pins
`timescale 1ns/100ps
module flash_command_decoder
  import flash_host_pkg::*;
#(
  parameter int ERASE_WINDOW = ERASE_WINDOW_CYC
)(
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  // user command port
  input  wire logic              cmd_valid_in,
  input  wire op_t               cmd_op_in,
  input  wire logic [ADDR_W-1:0] cmd_addr_in,
  input  wire logic [DATA_W-1:0] cmd_data_in,
  input  wire logic [11:0]       cmd_id_ofs_in,
  output logic                   cmd_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_data_out,
  // decoded status
  output logic                   completion_polarity_bit_out,
  output logic                   activity_toggle_bit_out,
  output logic                   toggling_out,
  output logic                   time_limit_flag_out,
  output logic                   erase_window_flag_out,
  output logic                   sector_toggle_bit_out,
  output logic                   device_busy_out,
  output logic                   window_open_out,
  output logic [7:0]             bank_suspended_out,
  output logic [7:0]             bank_id_mode_out,
  output logic                   bypass_mode_out,
  // flash pins
  output logic [ADDR_W-1:0]      pin_addr_out,
  output logic [DATA_W-1:0]      pin_data_out,
  output logic                   pin_data_oe_out,
  input  wire logic [DATA_W-1:0] pin_data_in,
  output logic                   chip_sel_n_out,
  output logic                   write_n_out,
  output logic                   read_n_out,
  input  wire logic              ready_busy_in
);

  // ==========================================================================
  // cycle channel to the pin driver and the sequence table
  flash_cycle_if cyc ();
  step_t         step;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} sstate_t;

  typedef struct packed {
    sstate_t              st;
    op_t                  op;
    logic [2:0]           idx;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    data;
    logic [11:0]          id_ofs;
    logic                 start;
    logic                 cmd_ready;
    logic                 rsp_valid;
    logic [DATA_W-1:0]    rsp_data;
    logic                 have_prev;
    logic                 prev_toggle;
    logic                 poll;
    logic                 toggle;
    logic                 toggling;
    logic                 limit;
    logic                 window;
    logic                 sect_tog;
    logic                 rb_s1;
    logic                 rb_s2;
    logic                 busy;
    logic [31:0]          win_cnt;
    logic                 win_open;
    logic [7:0]           suspended;
    logic [7:0]           id_mode;
    logic                 bypass;
  } top_state_t;

  top_state_t s_reg;
  top_state_t s_next;

  // bank index of an address
  function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
    bank_of = a[BANK_LSB +: BANK_W];
  endfunction

  flash_seq_rom u_rom (
    .op_in     (s_reg.op),
    .idx_in    (s_reg.idx),
    .id_ofs_in (s_reg.id_ofs),
    .step_out  (step)
  );

  flash_bus_driver u_drv (
    .clock_in        (clock_in),
    .reset_in        (reset_in),
    .cyc             (cyc.drv),
    .pin_addr_out    (pin_addr_out),
    .pin_data_out    (pin_data_out),
    .pin_data_oe_out (pin_data_oe_out),
    .pin_data_in     (pin_data_in),
    .chip_sel_n_out  (chip_sel_n_out),
    .write_n_out     (write_n_out),
    .read_n_out      (read_n_out)
  );

  // compose address and data of the current step
  always_comb begin
    cyc.is_read = step.is_read;
    cyc.start   = s_reg.start;
    if (step.use_full)
      cyc.addr = s_reg.addr;
    else if (step.use_bank && step.is_read)
      cyc.addr = {s_reg.addr[ADDR_W-1:SECT_LSB], step.ofs};
    else if (step.use_bank)
      cyc.addr = {bank_of(s_reg.addr), {(ADDR_W - BANK_W - 12){1'b0}}, step.ofs};
    else
      cyc.addr = {{(ADDR_W - 12){1'b0}}, step.ofs};
    // upper byte of command writes left zero since the device ignores it
    cyc.wdata = step.use_word ? s_reg.data : {8'h00, step.code};
  end

  // sequencer, status decode and per-bank mode tracking
  always_comb begin
    s_next           = s_reg;
    s_next.start     = 1'b0;
    s_next.rsp_valid = 1'b0;
    s_next.rb_s1     = ready_busy_in;
    s_next.rb_s2     = s_reg.rb_s1;
    s_next.busy      = !s_reg.rb_s2;
    // host-side view of the sector erase acceptance window
    if (s_reg.win_cnt != 32'h0)
      s_next.win_cnt = s_reg.win_cnt - 32'h1;
    unique case (s_reg.st)
      S_IDLE: begin
        if (cmd_valid_in && s_reg.cmd_ready) begin
          s_next.op        = cmd_op_in;
          s_next.addr      = cmd_addr_in;
          s_next.data      = cmd_data_in;
          s_next.id_ofs    = cmd_id_ofs_in;
          s_next.idx       = 3'd0;
          s_next.cmd_ready = 1'b0;
          s_next.st        = S_ISSUE;
        end
      end
      S_ISSUE: begin
        s_next.start = 1'b1;
        s_next.st    = S_WAIT;
      end
      S_WAIT: begin
        if (cyc.done) begin
          if (step.last) begin
            s_next.rsp_valid = 1'b1;
            s_next.rsp_data  = cyc.rdata;
            s_next.cmd_ready = 1'b1;
            s_next.st        = S_IDLE;
            unique case (s_reg.op)
              OP_POLL: begin
                s_next.poll     = cyc.rdata[POLL_BIT];
                s_next.toggle   = cyc.rdata[TOGGLE_BIT];
                s_next.limit    = cyc.rdata[LIMIT_BIT];
                s_next.window   = cyc.rdata[WINDOW_BIT];
                s_next.sect_tog = s_reg.have_prev && (cyc.rdata[SECTOR_BIT] != s_reg.rsp_data[SECTOR_BIT]);
                s_next.toggling = s_reg.have_prev && (cyc.rdata[TOGGLE_BIT] != s_reg.prev_toggle);
                s_next.prev_toggle = cyc.rdata[TOGGLE_BIT];
                s_next.have_prev   = 1'b1;
              end
              OP_RESET: s_next.id_mode[bank_of(s_reg.addr)] = 1'b0;
              OP_IDENT: s_next.id_mode[bank_of(s_reg.addr)] = 1'b1;
              OP_BYPASS_ENTER: s_next.bypass = 1'b1;
              OP_BYPASS_EXIT:  s_next.bypass = 1'b0;
              OP_SECTOR_ERASE: s_next.win_cnt = 32'(ERASE_WINDOW);
              OP_SUSPEND: begin
                s_next.suspended[bank_of(s_reg.addr)] = 1'b1;
                s_next.win_cnt = 32'h0;
              end
              OP_RESUME:  s_next.suspended[bank_of(s_reg.addr)] = 1'b0;
              default: s_next.have_prev = 1'b0;
            endcase
          end else begin
            s_next.idx = s_reg.idx + 3'd1;
            s_next.st  = S_ISSUE;
          end
        end
      end
      default: s_next.st = S_IDLE;
    endcase
    s_next.win_open = (s_next.win_cnt != 32'h0);
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s_reg           <= '0;
      s_reg.st        <= S_IDLE;
      s_reg.op        <= OP_READ;
      s_reg.cmd_ready <= 1'b1;
      s_reg.rb_s1     <= 1'b1;
      s_reg.rb_s2     <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign cmd_ready_out               = s_reg.cmd_ready;
  assign rsp_valid_out               = s_reg.rsp_valid;
  assign rsp_data_out                = s_reg.rsp_data;
  assign completion_polarity_bit_out = s_reg.poll;
  assign activity_toggle_bit_out     = s_reg.toggle;
  assign toggling_out                = s_reg.toggling;
  assign time_limit_flag_out         = s_reg.limit;
  assign erase_window_flag_out       = s_reg.window;
  assign sector_toggle_bit_out       = s_reg.sect_tog;
  assign device_busy_out             = s_reg.busy;
  assign window_open_out             = s_reg.win_open;
  assign bank_suspended_out          = s_reg.suspended;
  assign bank_id_mode_out            = s_reg.id_mode;
  assign bypass_mode_out             = s_reg.bypass;

endmodule : flash_command_decoder

/* File: sim/flash_cmd_checker.sv */
// concurrent checks on the flash host pins and command port
`timescale 1ns/100ps
module flash_cmd_checker
  import flash_host_pkg::*;
(
  // clock, reset and command port
  input wire logic              clock_in, reset_in, cmd_valid_in, cmd_ready_out, rsp_valid_out,
  // flash pins and synced busy
  input wire logic [ADDR_W-1:0] pin_addr_out,
  input wire logic [DATA_W-1:0] pin_data_out,
  input wire logic              pin_data_oe_out, chip_sel_n_out, write_n_out, read_n_out,
  input wire logic              ready_busy_in, device_busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // =====
  // strobes
  strobe_excl_a: assert property (write_n_out || read_n_out) else $error("both strobes low");
  write_sel_a: assert property (!write_n_out |-> !chip_sel_n_out && pin_data_oe_out) else $error("bad write");
  read_float_a: assert property (!read_n_out |-> !chip_sel_n_out && !pin_data_oe_out) else $error("bad read");
  // both latch points must see one address and one word
  hold_bus_a: assert property (!write_n_out && !$past(write_n_out) |-> $stable(pin_addr_out) && $stable(pin_data_out))
    else $error("bus moved under strobe");
  strobe_len_a: assert property ($fell(write_n_out) |-> !write_n_out[*2]) else $error("strobe too short");
  unlock_clean_a: assert property (!write_n_out && pin_addr_out[11:0] == 12'h2AA && pin_data_out[7:0] == 8'h55
    |-> pin_data_out[15:8] == 8'h00 && pin_addr_out[21:12] == 10'h000) else $error("unlock upper bits");
  // command port and busy sync
  take_busy_a: assert property (cmd_valid_in && cmd_ready_out |=> !cmd_ready_out) else $error("take ignored");
  rsp_pulse_a: assert property (rsp_valid_out |-> cmd_ready_out ##1 !rsp_valid_out) else $error("bad answer");
  busy_on_a: assert property (!ready_busy_in[*4] |-> device_busy_out) else $error("busy missed");
  busy_off_a: assert property (ready_busy_in[*4] |-> !device_busy_out) else $error("busy stuck");
  cover property ($fell(write_n_out));
  cover property ($fell(read_n_out));
  cover property (device_busy_out && rsp_valid_out);
endmodule // flash_cmd_checker

bind flash_command_decoder flash_cmd_checker chk (.clock_in, .reset_in, .cmd_valid_in, .cmd_ready_out,
  .rsp_valid_out, .pin_addr_out, .pin_data_out, .pin_data_oe_out, .chip_sel_n_out, .write_n_out,
  .read_n_out, .ready_busy_in, .device_busy_out);

/* File: sim/flash_dev_model.sv */
// behavioural flash die answering the host's bus cycles
`timescale 1ns/100ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER = 8'h5C  // arbitrary value
)(
  // pins
  input  wire logic              clock_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              we_n_in,
  input  wire logic              oe_n_in,
  output logic [DATA_W-1:0]      data_out,
  output logic                   rdy_out
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] la;
  logic [7:0]        d;
  logic              idm = 0, byp = 0, pend = 0, susp = 0, ers = 0, tog = 0;
  int                st = 0, busy = 0;
  assign rdy_out = !(busy > 0 && !susp);
  // embedded timer; one erase clears the whole model array
  always @(posedge clock_in) if (busy > 0 && !susp) begin
    if (busy == 1 && ers) mem.delete();
    if (busy == 1) ers = 0;
    busy = busy - 1;
  end
  // read answers; a released bus shows the inverse of the last word
  always @(negedge oe_n_in) begin
    if (idm) data_out = (addr_in[11:0] == ID_PROT_OFS) ? 16'h0001 : {8'h00, MAKER};
    else if (busy > 0) begin
      tog = tog ^ !susp;
      data_out = {8'h00, ers && susp, tog, 6'h00};
    end else data_out = mem.exists(addr_in) ? mem[addr_in] : 16'hFFFF;
  end
  always @(posedge oe_n_in) data_out = ~data_out;
  always @(negedge we_n_in) la = addr_in;
  // command decode on the strobe's rise; low byte and low address only
  always @(posedge we_n_in) begin
    d = data_in[7:0];
    if (pend) begin mem[la] = data_in; busy = 60; pend = 0; st = 0; end
    else if (st == 9) begin byp = (d != CODE_EXIT_ZERO); st = 0; end
    else if (d == CODE_RESET || d == CODE_EXIT_ZERO) begin idm = 0; st = 0; end
    else if (d == CODE_SUSPEND && ers) susp = 1;
    else if (byp) begin pend = (d == CODE_PROGRAM); st = (d == CODE_IDENT) ? 9 : 0; end
    else if (d == CODE_UNLOCK_A && la[11:0] == UNLOCK_ADDR_A && (st == 0 || st == 3)) st++;
    else if (d == CODE_UNLOCK_B && la[11:0] == UNLOCK_ADDR_B && (st == 1 || st == 4)) st++;
    else if (st == 2 && la[11:0] == UNLOCK_ADDR_A) begin
      st = (d == CODE_ERASE_SET) ? 3 : 0;
      idm = (d == CODE_IDENT);
      pend = (d == CODE_PROGRAM);
      byp = (d == CODE_BYPASS);
    end else if (st == 5 && (d == CODE_CHIP_ERS || d == CODE_SECT_ERS)) begin ers = 1; busy = 200; st = 0; end
    else if (d == CODE_RESUME && susp) susp = 0;
    else st = 0;
  end
endmodule // flash_dev_model

/* File: sim/tb_top.sv */
// testbench: user operations into the flash host, checked against a device model
`timescale 1ns/100ps
module tb_top;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'hC3; // arbitrary value
  localparam logic [ADDR_W-1:0] A = 22'h0A1234, B = 22'h2B0040;
  logic              clock_in = 0, reset_in = 1, cmd_valid_in = 0, ready, rsp_valid, oe, cs_n, we_n, rd_n, rdy;
  logic              pol, tgl, busy, byp;
  op_t               cmd_op_in = OP_READ;
  logic [ADDR_W-1:0] cmd_addr_in = '0, pin_addr;
  logic [DATA_W-1:0] cmd_data_in = '0, rsp, dout, dev;
  logic [11:0]       cmd_id_ofs_in = '0;
  wire  [DATA_W-1:0] bus = oe ? dout : dev;
  op_t               misc [5] = '{OP_QUERY, OP_RESET, OP_OTP_ENTER, OP_OTP_EXIT, OP_CHIP_ERASE};
  int                miscompares = 0, checks = 0;
  always #20 clock_in = ~clock_in;
  flash_command_decoder #(.ERASE_WINDOW(20)) dut (.clock_in, .reset_in, .cmd_valid_in, .cmd_op_in,
    .cmd_addr_in, .cmd_data_in, .cmd_id_ofs_in, .cmd_ready_out(ready), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp), .completion_polarity_bit_out(pol), .activity_toggle_bit_out(), .toggling_out(tgl),
    .time_limit_flag_out(), .erase_window_flag_out(), .sector_toggle_bit_out(), .device_busy_out(busy),
    .window_open_out(), .bank_suspended_out(), .bank_id_mode_out(), .bypass_mode_out(byp),
    .pin_addr_out(pin_addr), .pin_data_out(dout), .pin_data_oe_out(oe), .pin_data_in(bus),
    .chip_sel_n_out(cs_n), .write_n_out(we_n), .read_n_out(rd_n), .ready_busy_in(rdy));
  flash_dev_model #(.MAKER(MAKER)) dev_i (.clock_in, .addr_in(pin_addr), .data_in(bus),
    .we_n_in(we_n | cs_n), .oe_n_in(rd_n | cs_n), .data_out(dev), .rdy_out(rdy));
  // =====
  // shared tasks
  task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
    checks++;
    if (seen !== exp) begin miscompares++; $display("MISMATCH %s expected %h seen %h", what, exp, seen); end
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bounded wait: on flag 1 for the answer pulse, else for the device to go idle
  task automatic wait_on(input bit ans);
    int n;
    if (!ans) repeat (4) @(negedge clock_in);
    for (n = 0; n < 900 && (ans ? rsp_valid !== 1'b1 : busy !== 1'b0); n++) @(negedge clock_in);
    if (n == 900) begin miscompares++; end_of_test; end
  endtask
  task automatic run(input op_t op, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt, input logic [11:0] of);
    @(posedge clock_in);
    cmd_op_in <= op; cmd_addr_in <= ad; cmd_data_in <= dt; cmd_id_ofs_in <= of; cmd_valid_in <= 1'b1;
    @(posedge clock_in);
    cmd_valid_in <= 1'b0;
    wait_on(1);
  endtask
  initial begin
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
    run(OP_PROGRAM, A, 16'h1234, 0);
    run(OP_POLL, A, 0, 0);
    run(OP_POLL, A, 0, 0);
    check("toggle busy", {14'h0, tgl, busy}, 16'h0003);
    wait_on(0);
    run(OP_READ, A, 0, 0);
    check("read", rsp, 16'h1234);
    run(OP_IDENT, A, 0, 0);
    run(OP_ID_READ, A, 0, ID_MAKER_OFS);
    check("maker", {8'h00, rsp[7:0]}, {8'h00, MAKER});
    run(OP_ID_READ, A, 0, ID_PROT_OFS);
    check("protect", rsp, 16'h0001);
    run(OP_RESET, A, 0, 0);
    run(OP_READ, A, 0, 0);
    check("after reset", rsp, 16'h1234);
    $display("program and ident test done");
    run(OP_BYPASS_ENTER, A, 0, 0);
    check("bypass on", {15'h0, byp}, 16'h0001);
    run(OP_BYPASS_PROGRAM, B, 16'hA55A, 0);
    wait_on(0);
    run(OP_BYPASS_EXIT, A, 0, 0);
    run(OP_READ, B, 0, 0);
    check("bypass word", {rsp[15:1], byp}, 16'hA55A);
    $display("bypass test done");
    run(OP_SECTOR_ERASE, A, 0, 0);
    run(OP_POLL, A, 0, 0);
    check("erasing", {14'h0, pol, busy}, 16'h0001);
    run(OP_SUSPEND, A, 0, 0);
    run(OP_POLL, A, 0, 0);
    check("suspended", {14'h0, pol, busy}, 16'h0002);
    run(OP_RESUME, A, 0, 0);
    run(OP_POLL, A, 0, 0);
    check("resumed", {14'h0, pol, busy}, 16'h0001);
    wait_on(0);
    run(OP_READ, A, 0, 0);
    check("erased", rsp, 16'hFFFF);
    foreach (misc[i]) run(misc[i], B, 0, 0);
    wait_on(0);
    run(OP_READ, B, 0, 0);
    check("chip erased", rsp, 16'hFFFF);
    $display("erase test done");
    end_of_test;
  end
endmodule // tb_top
